// ==== design/ufd_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module ufd_ctrl
    import ufd_pkg::*;
#(
    parameter int  DEPTH = FIFO_DEPTH,
    localparam int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // Host register port.
    input  wire logic [2:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    // Transmit characters toward the shifter.
    output logic                   tx_data_valid,
    input  wire logic              tx_data_ready,
    output logic      [DATA_W-1:0] tx_data,
    input  wire logic              tx_shift_empty,
    // Received characters from the shifter.
    input  wire logic              rx_char_valid,
    output logic                   rx_char_ready,
    input  wire logic [DATA_W-1:0] rx_char_data,
    input  wire logic [ERR_W-1:0]  rx_char_err,
    input  wire logic              rx_timeout,
    // Interrupt and DMA request outputs.
    output logic                   rx_data_irq,
    output logic                   tx_ready_n,
    output logic                   rx_ready_n
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]        fifo_control_reg;
    logic [MASK_W-1:0] interrupt_mask_reg;
    logic [7:0]        rdata_reg;
    logic              overrun_reg;
    logic              timeout_reg;
    logic [CW-1:0]     err_cnt_reg;
    logic              rx_irq_reg;
    logic              tx_ready_n_reg;
    logic              rx_ready_n_reg;
    ufd_rxd_state_t    rxd_reg;
    ufd_rxd_state_t    rxd_next;

    logic [CW-1:0]            tx_count;
    logic [CW-1:0]            rx_count;
    logic                     tx_fifo_ready;
    logic                     rx_fifo_ready;
    logic                     rx_head_valid;
    logic [DATA_W+ERR_W-1:0]  rx_head;

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode.
    wire fc_wr       = reg_wr && (reg_addr == ADDR_FIFO_CTRL);
    wire mask_wr     = reg_wr && (reg_addr == ADDR_INT_MASK);
    wire hold_wr     = reg_wr && (reg_addr == ADDR_HOLDING);
    wire hold_rd     = reg_rd && (reg_addr == ADDR_HOLDING);
    wire status_rd   = reg_rd && (reg_addr == ADDR_LINE_STATUS);

    wire fifo_en     = fifo_control_reg[FC_ENABLE];
    wire dma_mode1   = fifo_en && fifo_control_reg[FC_DMA_MODE];
    wire [1:0] trig_code = fifo_control_reg[FC_TRIG_HI:FC_TRIG_LO];
    wire tx_fifo_clear = fifo_control_reg[FC_TX_CLEAR];
    wire rx_fifo_clear = fifo_control_reg[FC_RX_CLEAR];
    wire polled_mode = fifo_en && (interrupt_mask_reg == INT_MASK_RESET);

    // Without the enable bit only the enable itself is taken.
    wire [7:0] fc_raw = reg_wdata[FC_ENABLE] ? (reg_wdata & FC_WRITE_MASK)
                                             : (fifo_control_reg & FC_FIELD_MASK);
    wire       en_change = (fc_raw[FC_ENABLE] != fifo_en);
    wire [7:0] fc_value = fc_raw | (en_change ? FC_CLEAR_BITS : 8'h00);
    wire [7:0] fifo_control_next = fc_wr ? fc_value
                                         : (fifo_control_reg & FC_HOLD_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit path.
    wire tx_accept = fifo_en ? tx_fifo_ready : (tx_count == '0);
    wire tx_push   = hold_wr && tx_accept;

    ufd_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .clear     (tx_fifo_clear),
        .in_valid  (tx_push),
        .in_ready  (tx_fifo_ready),
        .in_data   (reg_wdata),
        .out_valid (tx_data_valid),
        .out_ready (tx_data_ready),
        .out_data  (tx_data),
        .count     (tx_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path; the FIFO keeps filling past the trigger level.
    wire rx_accept = fifo_en ? rx_fifo_ready : (rx_count == '0);
    wire rx_push   = rx_char_valid && rx_accept;
    wire rx_lost   = rx_char_valid && !rx_accept;
    wire rx_pop    = hold_rd && rx_head_valid;
    wire [ERR_W-1:0] head_err = rx_head[DATA_W +: ERR_W];

    assign rx_char_ready = rx_accept;

    ufd_fifo #(
        .WIDTH (DATA_W + ERR_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .clear     (rx_fifo_clear),
        .in_valid  (rx_char_valid && rx_accept),
        .in_ready  (rx_fifo_ready),
        .in_data   ({rx_char_err, rx_char_data}),
        .out_valid (rx_head_valid),
        .out_ready (hold_rd),
        .out_data  (rx_head),
        .count     (rx_count)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger, status and ready decoding.
    wire rx_trig    = fifo_en && (rx_count >= CW'(trig_level(trig_code)));
    wire rx_level   = fifo_en ? rx_trig : rx_head_valid;
    wire rx_pending = interrupt_mask_reg[IM_RX_DATA] && (rx_level || timeout_reg);
    wire [3:0] isr_code = !rx_pending ? ISR_NONE
                        : (timeout_reg ? ISR_RX_TIMEOUT : ISR_RX_DATA);
    wire [7:0] isr_value = {fifo_en, fifo_en, 2'b00, isr_code};

    wire [7:0] line_status;
    assign line_status[LS_DATA_READY]         = rx_head_valid;
    assign line_status[LS_OVERRUN]            = overrun_reg;
    assign line_status[LS_ERR_HI:LS_ERR_LO]   = rx_head_valid ? head_err : '0;
    assign line_status[LS_TX_EMPTY]           = (tx_count == '0);
    assign line_status[LS_TX_IDLE]            = (tx_count == '0) && tx_shift_empty;
    assign line_status[LS_FIFO_ERR]           = fifo_en && (err_cnt_reg != '0);

    wire [7:0] read_value = (reg_addr == ADDR_HOLDING)     ? rx_head[DATA_W-1:0]
                          : (reg_addr == ADDR_INT_MASK)    ? {4'h0, interrupt_mask_reg}
                          : (reg_addr == ADDR_FIFO_CTRL)   ? isr_value
                          : (reg_addr == ADDR_LINE_STATUS) ? line_status
                          : 8'h00;

    wire err_in   = rx_push && (rx_char_err != '0);
    wire err_out  = rx_pop && (head_err != '0);
    wire [CW-1:0] err_cnt_next = rx_fifo_clear ? '0
                               : err_cnt_reg + CW'(err_in) - CW'(err_out);
    wire overrun_next = rx_lost || (overrun_reg && !status_rd);
    wire timeout_set  = fifo_en && rx_timeout && rx_head_valid;
    wire timeout_next = timeout_set || (timeout_reg && !rx_pop && !rx_fifo_clear);

    wire tx_ready_n_next = dma_mode1 ? (tx_count == CW'(DEPTH))
                                     : (tx_count != '0);

    always_comb
    begin
        rxd_next = rxd_reg;
        case (rxd_reg)
            rxd_idle:
            begin
                if (dma_mode1 && (rx_trig || timeout_reg))
                    rxd_next = rxd_active;
            end
            rxd_active:
            begin
                if (!dma_mode1 || (rx_count == '0))
                    rxd_next = rxd_idle;
            end
            default: rxd_next = rxd_idle;
        endcase
    end

    wire rx_ready_n_next = dma_mode1 ? (rxd_next != rxd_active)
                                     : (rx_count == '0);

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fifo_control_reg   <= FIFO_CTRL_RESET;
            interrupt_mask_reg <= INT_MASK_RESET;
            rdata_reg          <= 8'h00;
            overrun_reg        <= 1'b0;
            timeout_reg        <= 1'b0;
            err_cnt_reg        <= '0;
        end
        else
        begin
            fifo_control_reg   <= fifo_control_next;
            interrupt_mask_reg <= mask_wr ? reg_wdata[MASK_W-1:0] : interrupt_mask_reg;
            rdata_reg          <= reg_rd ? read_value : rdata_reg;
            overrun_reg        <= overrun_next;
            timeout_reg        <= timeout_next;
            err_cnt_reg        <= err_cnt_next;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxd_reg        <= rxd_idle;
            rx_irq_reg     <= 1'b0;
            tx_ready_n_reg <= 1'b0;
            rx_ready_n_reg <= 1'b1;
        end
        else
        begin
            rxd_reg        <= rxd_next;
            rx_irq_reg     <= rx_pending;
            tx_ready_n_reg <= tx_ready_n_next;
            rx_ready_n_reg <= rx_ready_n_next;
        end
    end

    assign reg_rdata   = rdata_reg;
    assign rx_data_irq = rx_irq_reg;
    assign tx_ready_n  = tx_ready_n_reg;
    assign rx_ready_n  = rx_ready_n_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_rx_armed;
        dma_mode1 && rx_trig;
    endsequence

    sequence s_rx_held;
        (dma_mode1 && (rx_count != '0) && !fc_wr) [*2];
    endsequence

    a_rx_irq_raise: assert property ((fifo_en && interrupt_mask_reg[IM_RX_DATA] && rx_trig)
        |=> rx_data_irq) else $error("receive interrupt missing at trigger");
    a_rx_irq_drop: assert property ((fifo_en && !rx_trig && !timeout_reg)
        |=> !rx_data_irq) else $error("receive interrupt stuck below trigger");
    a_isr_trigger: assert property ((fifo_en && interrupt_mask_reg[IM_RX_DATA] && rx_trig
        && !timeout_reg) |-> (isr_value[3:0] == ISR_RX_DATA))
        else $error("status code wrong at trigger");
    a_data_ready: assert property ((rx_push && !rx_fifo_clear)
        |=> line_status[LS_DATA_READY]) else $error("data ready not set");
    a_fifo_error: assert property ((fifo_en && err_in && !rx_fifo_clear && !fc_wr)
        |=> line_status[LS_FIFO_ERR]) else $error("fifo error flag missing");
    a_tx_empty: assert property ((tx_push && !tx_fifo_clear)
        |=> !line_status[LS_TX_EMPTY] && !line_status[LS_TX_IDLE])
        else $error("transmit empty after write");
    a_tx_ready_n_mode0: assert property ((!dma_mode1 && (tx_count == '0) && !hold_wr)
        |=> !tx_ready_n) else $error("transmit ready high while empty");
    a_rx_ready_n_mode0: assert property ((!dma_mode1 && (rx_count != '0) && !hold_rd && !fc_wr)
        |=> !rx_ready_n) else $error("receive ready high with data");
    a_tx_ready_n_mode1: assert property ((dma_mode1 && !fc_wr && (tx_count == CW'(DEPTH))
        && !tx_data_ready) |=> tx_ready_n) else $error("transmit ready low when full");
    a_rx_ready_n_mode1: assert property (s_rx_armed ##1 s_rx_held |-> !rx_ready_n)
        else $error("receive ready released with data");
    a_rx_fill_on: assert property ((rx_trig && (rx_count < CW'(DEPTH))) |-> rx_char_ready)
        else $error("receive stalled above trigger");
    a_clear_pulse: assert property ((tx_fifo_clear || rx_fifo_clear) && !fc_wr
        |=> !tx_fifo_clear && !rx_fifo_clear && (rx_count == '0 || !$past(rx_fifo_clear)))
        else $error("clear bit did not return to zero");
    a_ctrl_ignore: assert property ((fc_wr && !reg_wdata[FC_ENABLE])
        |=> !fifo_en && $stable(trig_code)) else $error("control bits taken without enable");

endmodule : ufd_ctrl
`default_nettype wire

// ==== design/ufd_pkg.sv ====
// How it works
// - Receive interrupt follows fill versus trigger level.
// - Status code shows trigger; clears below level.
// - Data ready set on store, until empty.
// - Polled mode: FIFOs on, all masks off.
// - Status bits report errors; bit 7 FIFO errors.
// - Bit 5 transmit empty; bit 6 fully idle.
// - Control bit 3 selects DMA mode.
// - Mode 0 transmit ready low when empty.
// - Mode 0 receive ready low while holding data.
// - Mode 1 transmit ready high only when full.
// - Mode 1 receive ready: trigger/time-out until empty.
// - Reception continues past trigger until full.
// - Control bits 7:6 program trigger level.
// - Control bits 5:4 unused, zero.
// - Control bit 2 requests transmit clear.
// - Clear bits empty FIFO, then self-clear.
// - Trigger codes give 1, 4, 8, 14.
// - Other control bits ignored unless enable set.
package ufd_pkg;

    localparam int DATA_W     = 8;
    localparam int ERR_W      = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = 5;
    localparam int MASK_W     = 4;

    localparam logic [2:0] ADDR_HOLDING     = 3'h0;
    localparam logic [2:0] ADDR_INT_MASK    = 3'h1;
    localparam logic [2:0] ADDR_FIFO_CTRL   = 3'h2;
    localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;

    localparam int FC_ENABLE   = 0;
    localparam int FC_RX_CLEAR = 1;
    localparam int FC_TX_CLEAR = 2;
    localparam int FC_DMA_MODE = 3;
    localparam int FC_TRIG_LO  = 6;
    localparam int FC_TRIG_HI  = 7;

    localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
    localparam logic [7:0] FC_WRITE_MASK   = 8'hcf;
    localparam logic [7:0] FC_FIELD_MASK   = 8'hf8;
    localparam logic [7:0] FC_HOLD_MASK    = 8'hf9;
    localparam logic [7:0] FC_CLEAR_BITS   = 8'h06;

    localparam logic [MASK_W-1:0] INT_MASK_RESET = 4'h0;
    localparam int                IM_RX_DATA     = 0;

    localparam logic [CNT_W-1:0] TRIG_LVL_0 = 5'h01;
    localparam logic [CNT_W-1:0] TRIG_LVL_1 = 5'h04;
    localparam logic [CNT_W-1:0] TRIG_LVL_2 = 5'h08;
    localparam logic [CNT_W-1:0] TRIG_LVL_3 = 5'h0e;

    localparam logic [3:0] ISR_NONE       = 4'h1;
    localparam logic [3:0] ISR_RX_DATA    = 4'h4;
    localparam logic [3:0] ISR_RX_TIMEOUT = 4'hc;

    localparam int LS_DATA_READY = 0;
    localparam int LS_OVERRUN    = 1;
    localparam int LS_ERR_LO     = 2;
    localparam int LS_ERR_HI     = 4;
    localparam int LS_TX_EMPTY   = 5;
    localparam int LS_TX_IDLE    = 6;
    localparam int LS_FIFO_ERR   = 7;

    typedef enum logic [1:0]
    {
        rxd_idle   = 2'b01,
        rxd_active = 2'b10
    } ufd_rxd_state_t;

    function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] code);
        case (code)
            2'h0:    trig_level = TRIG_LVL_0;
            2'h1:    trig_level = TRIG_LVL_1;
            2'h2:    trig_level = TRIG_LVL_2;
            default: trig_level = TRIG_LVL_3;
        endcase
    endfunction : trig_level

endpackage : ufd_pkg

// ==== design/ufd_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
module ufd_fifo #(
    parameter int  WIDTH = 8,
    parameter int  DEPTH = 16,
    localparam int AW    = $clog2(DEPTH),
    localparam int CW    = $clog2(DEPTH + 1)
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clear,
    // Fill side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [CW-1:0]    count
);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    wire              push     = in_valid && in_ready;
    wire              pop      = out_valid && out_ready;
    wire [AW-1:0]     wr_next  = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    wire [AW-1:0]     rd_next  = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;

    assign in_ready  = (count_reg != CW'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign count     = count_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (clear)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            wr_ptr_reg <= push ? wr_next : wr_ptr_reg;
            rd_ptr_reg <= pop ? rd_next : rd_ptr_reg;
            count_reg  <= count_reg + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

endmodule : ufd_fifo
`default_nettype wire

// ==== verif/ufd_shifter_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ufd_shifter_model
    import ufd_pkg::*;
(
    // Clock and stall control.
    input  wire logic              clk,
    input  wire logic              stall,
    // Transmit side.
    input  wire logic              tx_data_valid,
    output logic                   tx_data_ready,
    output logic                   tx_shift_empty,
    // Receive side.
    output logic                   rx_char_valid,
    output logic      [DATA_W-1:0] rx_char_data,
    output logic      [ERR_W-1:0]  rx_char_err,
    output logic                   rx_timeout
);

    int busy_cnt = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // The shifter stays busy for three cycles after taking a character.
    assign tx_data_ready  = ~stall;
    assign tx_shift_empty = (busy_cnt == 0);

    always @(posedge clk)
    begin
        if (tx_data_valid && tx_data_ready)
            busy_cnt <= 3;
        else if (busy_cnt > 0)
            busy_cnt <= busy_cnt - 1;
    end

    initial
    begin
        rx_char_valid = 1'b0;
        rx_char_data  = 8'h00;
        rx_char_err   = 3'h0;
        rx_timeout    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Released receive lines show the inverse of the last value.
    task automatic send_char(input logic [DATA_W-1:0] d, input logic [ERR_W-1:0] e);
        @(posedge clk);
        #5;
        rx_char_valid = 1'b1;
        rx_char_data  = d;
        rx_char_err   = e;
        @(posedge clk);
        #5;
        rx_char_valid = 1'b0;
        rx_char_data  = ~d;
        rx_char_err   = ~e;
    endtask : send_char

    task automatic pulse_timeout();
        @(posedge clk);
        #5;
        rx_timeout = 1'b1;
        @(posedge clk);
        #5;
        rx_timeout = 1'b0;
    endtask : pulse_timeout

endmodule : ufd_shifter_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
        failures++; \
        $display("wrong value %s expected %h seen %h", what, exp, got); \
    end
module tb_top
    import ufd_pkg::*;
;
    logic              clk;
    logic              rst;
    logic              stall;
    logic [2:0]        reg_addr;
    logic              reg_wr;
    logic              reg_rd;
    logic [7:0]        reg_wdata;
    logic [7:0]        reg_rdata;
    logic              tx_data_valid;
    logic              tx_data_ready;
    logic [DATA_W-1:0] tx_data;
    logic              tx_shift_empty;
    logic              rx_char_valid;
    logic              rx_char_ready;
    logic [DATA_W-1:0] rx_char_data;
    logic [ERR_W-1:0]  rx_char_err;
    logic              rx_timeout;
    logic              rx_data_irq;
    logic              tx_ready_n;
    logic              rx_ready_n;
    logic              rd_taken = 1'b0;
    logic [7:0]        exp_rd;
    logic [7:0]        exp_tx;
    logic [7:0]        rdq[$];
    logic [7:0]        txq[$];
    logic [7:0]        exp_rx[$];
    int                failures = 0;
    int                check_count = 0;
    integer            seed = 48;
    int                lvl[4] = '{1, 4, 8, 14};

    ufd_ctrl #(.DEPTH(FIFO_DEPTH)) i_ufd_ctrl (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready), .tx_data(tx_data),
        .tx_shift_empty(tx_shift_empty), .rx_char_valid(rx_char_valid),
        .rx_char_ready(rx_char_ready), .rx_char_data(rx_char_data), .rx_char_err(rx_char_err),
        .rx_timeout(rx_timeout), .rx_data_irq(rx_data_irq), .tx_ready_n(tx_ready_n),
        .rx_ready_n(rx_ready_n));

    ufd_shifter_model i_ufd_shifter_model (.clk(clk), .stall(stall),
        .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready),
        .tx_shift_empty(tx_shift_empty), .rx_char_valid(rx_char_valid),
        .rx_char_data(rx_char_data), .rx_char_err(rx_char_err), .rx_timeout(rx_timeout));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and result watcher.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (rd_taken)
        begin
            exp_rd = rdq.pop_front();
            `CHK("reg_rdata", exp_rd, reg_rdata)
        end
        if (tx_data_valid && tx_data_ready)
        begin
            exp_tx = txq.pop_front();
            `CHK("tx_data", exp_tx, tx_data)
        end
        rd_taken <= reg_rd;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Host tasks.
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        #5;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #5;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        #5;
        reg_addr = a;
        reg_rd   = 1'b1;
        rdq.push_back(exp);
        @(posedge clk);
        #5;
        reg_rd = 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : idle

    task automatic tx_put(input logic keep);
        logic [7:0] d;
        d = 8'($random(seed));
        wr(ADDR_HOLDING, d);
        if (keep)
            txq.push_back(d);
    endtask : tx_put

    task automatic rx_put(input logic [ERR_W-1:0] e);
        logic [7:0] d;
        d = 8'($random(seed));
        exp_rx.push_back(d);
        i_ufd_shifter_model.send_char(d, e);
    endtask : rx_put

    task automatic rx_get();
        rd(ADDR_HOLDING, exp_rx.pop_front());
    endtask : rx_get

    task automatic drain();
        int n;
        stall = 1'b0;
        for (n = 0; n < 100 && tx_data_valid !== 1'b0; n++)
        begin
            @(posedge clk);
            #5;
        end
        if (n == 100)
        begin
            failures++;
            tally_and_finish();
        end
        stall = 1'b1;
    endtask : drain

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        rst       = 1'b1;
        stall     = 1'b1;
        reg_addr  = 3'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
        repeat (8) @(posedge clk);
        #5;
        rst = 1'b0;
        `CHK("tx_ready_n", 1'b0, tx_ready_n)
        `CHK("rx_ready_n", 1'b1, rx_ready_n)
        rd(ADDR_LINE_STATUS, 8'h60);
        rd(3'h7, 8'h00);
        tx_put(1'b1);
        idle(3);
        `CHK("tx_ready_n", 1'b1, tx_ready_n)
        rd(ADDR_LINE_STATUS, 8'h00);
        drain();
        idle(6);
        `CHK("tx_ready_n", 1'b0, tx_ready_n)
        rd(ADDR_LINE_STATUS, 8'h60);
        rx_put(3'h0);
        idle(3);
        `CHK("rx_ready_n", 1'b0, rx_ready_n)
        rx_get();
        idle(3);
        `CHK("rx_ready_n", 1'b1, rx_ready_n)
        wr(ADDR_INT_MASK, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_FIFO_CTRL, {c[1:0], 6'h07});
            exp_rx.delete();
            rd(ADDR_LINE_STATUS, 8'h60);
            for (int i = 1; i < lvl[c]; i++)
                rx_put(3'h0);
            idle(3);
            `CHK("rx_data_irq", 1'b0, rx_data_irq)
            rd(ADDR_FIFO_CTRL, 8'hc1);
            rx_put(3'h0);
            idle(3);
            `CHK("rx_data_irq", 1'b1, rx_data_irq)
            rd(ADDR_FIFO_CTRL, 8'hc4);
            rd(ADDR_LINE_STATUS, 8'h61);
            rx_get();
            idle(3);
            `CHK("rx_data_irq", 1'b0, rx_data_irq)
            rd(ADDR_FIFO_CTRL, 8'hc1);
        end
        wr(ADDR_INT_MASK, 8'h00);
        wr(ADDR_FIFO_CTRL, 8'h03);
        exp_rx.delete();
        rx_put(3'h2);
        repeat (FIFO_DEPTH - 1) rx_put(3'h0);
        i_ufd_shifter_model.send_char(8'h5a, 3'h0);
        `CHK("rx_char_ready", 1'b0, rx_char_ready)
        idle(3);
        `CHK("rx_data_irq", 1'b0, rx_data_irq)
        `CHK("rx_ready_n", 1'b0, rx_ready_n)
        rd(ADDR_LINE_STATUS, 8'heb);
        repeat (FIFO_DEPTH) rx_get();
        rd(ADDR_LINE_STATUS, 8'h60);
        wr(ADDR_FIFO_CTRL, 8'h4f);
        idle(3);
        `CHK("tx_ready_n", 1'b0, tx_ready_n)
        `CHK("rx_ready_n", 1'b1, rx_ready_n)
        repeat (FIFO_DEPTH - 1) tx_put(1'b1);
        idle(3);
        `CHK("tx_ready_n", 1'b0, tx_ready_n)
        tx_put(1'b1);
        tx_put(1'b0);
        idle(3);
        `CHK("tx_ready_n", 1'b1, tx_ready_n)
        wr(ADDR_FIFO_CTRL, 8'h4d);
        txq.delete();
        idle(3);
        `CHK("tx_data_valid", 1'b0, tx_data_valid)
        `CHK("tx_ready_n", 1'b0, tx_ready_n)
        tx_put(1'b1);
        tx_put(1'b1);
        drain();
        repeat (3) rx_put(3'h0);
        idle(3);
        `CHK("rx_ready_n", 1'b1, rx_ready_n)
        rx_put(3'h0);
        idle(3);
        `CHK("rx_ready_n", 1'b0, rx_ready_n)
        repeat (3) rx_get();
        idle(3);
        `CHK("rx_ready_n", 1'b0, rx_ready_n)
        rx_get();
        idle(3);
        `CHK("rx_ready_n", 1'b1, rx_ready_n)
        rx_put(3'h0);
        i_ufd_shifter_model.pulse_timeout();
        idle(3);
        `CHK("rx_ready_n", 1'b0, rx_ready_n)
        rx_get();
        idle(3);
        `CHK("rx_ready_n", 1'b1, rx_ready_n)
        tally_and_finish();
    end

endmodule : tb_top
`default_nettype wire
